//--- hdl/rsx_params.svh
// Behaviour
// - rotate left through carry, bit7 to carry
// - rotate right through carry, bit0 to carry
// - destination bit 0 to work, 1 to file
// - power-down clears watchdog counter and prescaler
// - power-down clears active-low powerdown status flag
// - power-down sets active-low timeout status flag
// - power-down halts the main oscillator
// - literal minus work into work register
// - file minus work routed by destination bit
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH

// byte offsets on the register bus
`define OFF_INSTR 12'h000
`define OFF_WORK 12'h004
`define OFF_STATUS 12'h008
// file registers sit at FILE_BASE + 4 * index, selected by address bits 11:9
`define FILE_SEL 3'h1
`define FILE_DEPTH 128

// instruction word fields
`define IN_OP_HI 18
`define IN_OP_LO 16
`define IN_LIT_HI 15
`define IN_LIT_LO 8
`define IN_DEST 7
`define IN_FADDR_HI 6
`define IN_BYTES 3'h7

// status register bit positions
`define ST_CARRY 0
`define ST_NIB 1
`define ST_ZERO 2
`define ST_POWERDOWN 3
`define ST_TIMEOUT 4
`define ST_SLEEP 5

// reset values
`define WORK_RST 8'h00
`define FILE_RST 8'h00
`define POWERDOWN_RST 1'b1
`define TIMEOUT_RST 1'b1

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hdl/rsx_pkg.sv
package rsx_pkg;
	// operation codes carried in the instruction word
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ROTL = 3'h1,
		OP_ROTR = 3'h2,
		OP_SUBL = 3'h3,
		OP_SUBF = 3'h4,
		OP_SLEEP = 3'h5
	} op_t;
endpackage

//--- hdl/rsx_alu.sv
`timescale 1ns/1ps
`default_nettype none
// combinational datapath for rotates and subtractions
module rsx_alu (
	input wire rsx_pkg::op_t op,
	input wire logic [7:0] file_val,
	input wire logic [7:0] lit,
	input wire logic [7:0] work,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out,
	output logic nib_out,
	output logic zero_out
);
	logic [7:0] sub_a; // minuend: literal or file value

	// pick the operand that the working register is taken from
	always_comb begin
		sub_a = (op == rsx_pkg::OP_SUBL) ? lit : file_val;
	end

	// result and flags per operation
	always_comb begin
		result = 8'h00;
		carry_out = carry_in;
		nib_out = 1'b0;
		zero_out = 1'b0;
		unique case (op)
			rsx_pkg::OP_ROTL: begin
				// old carry into bit 0, bit 7 out
				result = {file_val[6:0], carry_in};
				carry_out = file_val[7];
			end
			rsx_pkg::OP_ROTR: begin
				// old carry into bit 7, bit 0 out
				result = {carry_in, file_val[7:1]};
				carry_out = file_val[0];
			end
			rsx_pkg::OP_SUBL, rsx_pkg::OP_SUBF: begin
				// two's complement difference, borrow shown as carry low
				result = sub_a - work;
				carry_out = (work <= sub_a);
				nib_out = (work[3:0] <= sub_a[3:0]);
				zero_out = ((sub_a - work) == 8'h00);
			end
			default: begin
				// no datapath work for other codes
				result = 8'h00;
			end
		endcase
	end
endmodule
`default_nettype wire

//--- hdl/rotate_subtract_sleep_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsx_params.svh"
// executes rotate, subtract and power-down instructions issued over the register bus
module rotate_subtract_sleep_exec (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic WAKE,
	output logic OSC_HALT,
	output logic WATCHDOG_CLEAR
);
	logic aw_full_q; // write address held
	logic [11:0] aw_addr_q; // held write address
	logic w_full_q; // write data held
	logic [31:0] w_data_q; // held write data
	logic [3:0] w_strb_q; // held byte strobes
	logic bvalid_q; // write answer pending
	logic [1:0] bresp_q; // write answer code
	logic rvalid_q; // read answer pending
	logic [31:0] rdata_q; // read answer data
	logic [1:0] rresp_q; // read answer code
	logic [7:0] work_q; // working register
	logic carry_q; // carry flag
	logic nib_q; // nibble_carry_flag
	logic zero_q; // zero flag
	logic powerdown_n_q; // powerdown_status_flag, active low
	logic timeout_n_q; // timeout_status_flag, active low
	logic asleep_q; // oscillator halted
	logic wd_clr_q; // watchdog counter and prescaler clear pulse
	logic [7:0] file_q [0:`FILE_DEPTH-1]; // file registers

	logic wr_do; // write performed this cycle
	logic sel_instr, sel_work, sel_status, sel_file; // write decode
	logic [6:0] w_idx; // file index of a bus write
	logic exec_go; // instruction runs this cycle
	rsx_pkg::op_t op; // decoded operation
	logic dest; // destination bit
	logic [6:0] faddr; // file operand address
	logic [7:0] lit; // literal operand
	logic [7:0] file_rd; // addressed file value
	logic [7:0] alu_res; // datapath result
	logic alu_c, alu_nib, alu_z; // datapath flags
	logic is_rot, is_sub; // operation groups
	logic to_file, to_work; // result routing
	logic ar_take; // read address taken
	logic [31:0] rd_mux; // read data select
	logic rd_hit; // read address mapped

	// handshake, oscillator halt and watchdog clear outputs
	assign AWREADY = !aw_full_q;
	assign WREADY = !w_full_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = !rvalid_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign OSC_HALT = asleep_q;
	assign WATCHDOG_CLEAR = wd_clr_q;

	// write decode on the held address
	assign wr_do = aw_full_q && w_full_q && !bvalid_q;
	assign sel_instr = ({aw_addr_q[11:2], 2'b00} == `OFF_INSTR);
	assign sel_work = ({aw_addr_q[11:2], 2'b00} == `OFF_WORK);
	assign sel_status = ({aw_addr_q[11:2], 2'b00} == `OFF_STATUS);
	assign sel_file = (aw_addr_q[11:9] == `FILE_SEL);
	assign w_idx = aw_addr_q[8:2];

	// instruction fields
	assign op = rsx_pkg::op_t'(w_data_q[`IN_OP_HI:`IN_OP_LO]);
	assign dest = w_data_q[`IN_DEST];
	assign faddr = w_data_q[`IN_FADDR_HI:0];
	assign lit = w_data_q[`IN_LIT_HI:`IN_LIT_LO];
	assign file_rd = file_q[faddr];

	// a halted core takes no instruction; strobes missing any of bytes 0 to 2 are ignored
	assign exec_go = wr_do && sel_instr && (w_strb_q[2:0] == `IN_BYTES) && !asleep_q;
	assign is_rot = (op == rsx_pkg::OP_ROTL) || (op == rsx_pkg::OP_ROTR);
	assign is_sub = (op == rsx_pkg::OP_SUBL) || (op == rsx_pkg::OP_SUBF);
	// literal subtract always lands in work, rotates and file subtract follow the destination bit
	assign to_file = exec_go && dest && (is_rot || (op == rsx_pkg::OP_SUBF));
	assign to_work = exec_go && ((!dest && (is_rot || (op == rsx_pkg::OP_SUBF)))
		|| (op == rsx_pkg::OP_SUBL));

	rsx_alu rsx_alu_i (
		.op(op),
		.file_val(file_rd),
		.lit(lit),
		.work(work_q),
		.carry_in(carry_q),
		.result(alu_res),
		.carry_out(alu_c),
		.nib_out(alu_nib),
		.zero_out(alu_z)
	);

	// write address and data channels, taken in either order
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			// capture address
			if (AWVALID && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= AWADDR;
			end else if (wr_do) begin
				aw_full_q <= 1'b0;
			end
			// capture data
			if (WVALID && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
			end else if (wr_do) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// write answer, error for unmapped addresses
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else if (wr_do) begin
			bvalid_q <= 1'b1;
			bresp_q <= (sel_instr || sel_work || sel_status || sel_file) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	// read select
	always_comb begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		if (ARADDR[11:9] == `FILE_SEL) begin
			rd_mux = {24'h000000, file_q[ARADDR[8:2]]};
		end else if ({ARADDR[11:2], 2'b00} == `OFF_WORK) begin
			rd_mux = {24'h000000, work_q};
		end else if ({ARADDR[11:2], 2'b00} == `OFF_STATUS) begin
			rd_mux[`ST_CARRY] = carry_q;
			rd_mux[`ST_NIB] = nib_q;
			rd_mux[`ST_ZERO] = zero_q;
			rd_mux[`ST_POWERDOWN] = powerdown_n_q;
			rd_mux[`ST_TIMEOUT] = timeout_n_q;
			rd_mux[`ST_SLEEP] = asleep_q;
		end else if ({ARADDR[11:2], 2'b00} != `OFF_INSTR) begin
			// instruction word reads as zero, anything else is unmapped
			rd_hit = 1'b0;
		end
	end

	assign ar_take = ARVALID && !rvalid_q;

	// read answer, one cycle after the address is taken
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// working register: bus write or instruction result
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			work_q <= `WORK_RST;
		end else if (to_work) begin
			work_q <= alu_res;
		end else if (wr_do && sel_work && w_strb_q[0]) begin
			work_q <= w_data_q[7:0];
		end
	end

	// file registers: bus write or instruction write-back
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			for (int i = 0; i < `FILE_DEPTH; i++) begin
				file_q[i] <= `FILE_RST;
			end
		end else if (to_file) begin
			file_q[faddr] <= alu_res;
		end else if (wr_do && sel_file && w_strb_q[0]) begin
			file_q[w_idx] <= w_data_q[7:0];
		end
	end

	// arithmetic flags: rotates touch carry only, subtractions all three
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			carry_q <= 1'b0;
			nib_q <= 1'b0;
			zero_q <= 1'b0;
		end else if (exec_go && is_rot) begin
			carry_q <= alu_c;
		end else if (exec_go && is_sub) begin
			carry_q <= alu_c;
			nib_q <= alu_nib;
			zero_q <= alu_z;
		end else if (wr_do && sel_status && w_strb_q[0]) begin
			carry_q <= w_data_q[`ST_CARRY];
			nib_q <= w_data_q[`ST_NIB];
			zero_q <= w_data_q[`ST_ZERO];
		end
	end

	// power-down: status flags, watchdog clear and oscillator halt
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			powerdown_n_q <= `POWERDOWN_RST;
			timeout_n_q <= `TIMEOUT_RST;
			asleep_q <= 1'b0;
			wd_clr_q <= 1'b0;
		end else begin
			wd_clr_q <= exec_go && (op == rsx_pkg::OP_SLEEP);
			if (exec_go && (op == rsx_pkg::OP_SLEEP)) begin
				powerdown_n_q <= 1'b0;
				timeout_n_q <= 1'b1;
				asleep_q <= 1'b1;
			end else if (WAKE) begin
				// wake-up restarts the oscillator
				asleep_q <= 1'b0;
			end
		end
	end

	// checking helpers
	logic [7:0] chk_rotl, chk_rotr, chk_subl, chk_subf, chk_other;
	logic file_msb;
	assign chk_rotl = {file_rd[6:0], carry_q};
	assign chk_rotr = {carry_q, file_rd[7:1]};
	assign chk_subl = lit - work_q;
	assign chk_subf = file_rd - work_q;
	assign chk_other = (op == rsx_pkg::OP_SUBL) ? lit : file_rd;
	assign file_msb = file_rd[7];

	a_rotl_to_work: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_ROTL && !dest |=> work_q == $past(chk_rotl))
		else $error("rotate left result wrong in work");
	a_rotr_to_file: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_ROTR && dest
		|=> file_q[$past(faddr)] == $past(chk_rotr) && $stable(work_q))
		else $error("rotate right result wrong in file");
	a_rotl_carry_out: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_ROTL |=> carry_q == $past(file_msb))
		else $error("rotate left carry wrong");
	a_rot_flags_kept: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && is_rot |=> $stable(zero_q) && $stable(nib_q))
		else $error("rotate changed zero or nibble carry");
	a_subl_result: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_SUBL |=> work_q == $past(chk_subl))
		else $error("literal subtract result wrong");
	a_subf_route: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_SUBF && !dest
		|=> work_q == $past(chk_subf) && file_q[$past(faddr)] == $past(file_rd))
		else $error("file subtract routing wrong");
	a_sub_flags: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && is_sub |=> carry_q == ($past(work_q) <= $past(chk_other))
		&& nib_q == ($past(work_q[3:0]) <= $past(chk_other[3:0]))
		&& zero_q == (($past(op) == rsx_pkg::OP_SUBL) ? ($past(chk_subl) == 8'h00)
		: ($past(chk_subf) == 8'h00)))
		else $error("subtract flags wrong");

	// rotate carry out of the low end and write-back into the file
	a_rotr_carry_out: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_ROTR |=> carry_q == $past(file_rd[0]))
		else $error("rotate right carry wrong");
	a_rotl_to_file: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_ROTL && dest
		|=> file_q[$past(faddr)] == $past(chk_rotl) && $stable(work_q))
		else $error("rotate left result wrong in file");

	// power-down effects and the halted state
	a_sleep_status: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_SLEEP |=> !powerdown_n_q && timeout_n_q && OSC_HALT)
		else $error("power-down status flags wrong");
	a_sleep_clears_watchdog: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		exec_go && op == rsx_pkg::OP_SLEEP |=> WATCHDOG_CLEAR ##1 !WATCHDOG_CLEAR)
		else $error("watchdog clear pulse wrong");
	a_halt_holds: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		OSC_HALT && !WAKE |=> OSC_HALT && !WATCHDOG_CLEAR)
		else $error("oscillator halt dropped without wake");
	// a halted core must not run an instruction written to it
	a_halted_refuses: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		asleep_q && wr_do && sel_instr |=> $stable(work_q) && $stable(carry_q))
		else $error("instruction ran while halted");
endmodule
`default_nettype wire

//--- bench/rotate_subtract_sleep_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: drives instructions and registers over the register bus
module rotate_subtract_sleep_exec_tb;
	logic SYS_CLK, SYS_RST; // clock and asynchronous reset
	logic [11:0] AWADDR, ARADDR; // write and read addresses
	logic AWVALID, WVALID, BREADY, ARVALID, RREADY, WAKE; // bus requests and wake
	logic [31:0] WDATA; // write data
	logic [3:0] WSTRB; // byte strobes
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, OSC_HALT, WATCHDOG_CLEAR; // design outputs
	logic [1:0] BRESP, RRESP; // bus answers
	logic [31:0] RDATA; // read data
	int miscompares = 0; // mismatches seen
	int comparisons = 0; // checks made
	int clear_pulses = 0; // watchdog clear pulses seen
	logic [1:0] resp; // last bus answer
	logic [31:0] rd; // last read word

	rotate_subtract_sleep_exec rotate_subtract_sleep_exec_i (
		.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.WAKE(WAKE), .OSC_HALT(OSC_HALT), .WATCHDOG_CLEAR(WATCHDOG_CLEAR)
	);

	// clock at 10 MHz
	initial begin
		SYS_CLK = 1'b0;
		forever #50 SYS_CLK = ~SYS_CLK;
	end

	// count watchdog clear pulses mid-cycle, where the pulse is settled
	always @(negedge SYS_CLK) begin
		if (WATCHDOG_CLEAR === 1'b1) begin
			clear_pulses++;
		end
	end

	// compare one value and report at once
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one bus write; ready and answer come from flops, so mid-cycle equals the next edge
	// each channel drops right after its taking edge; only the watchdog ends a hang
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic p_aw, p_w, p_b, aw_ok, w_ok, b_ok;
		p_aw = 1'b1;
		p_w = 1'b1;
		p_b = 1'b1;
		AWADDR <= a;
		AWVALID <= 1'b1;
		WDATA <= d;
		WSTRB <= s;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (p_aw || p_w || p_b) begin
			@(negedge SYS_CLK);
			aw_ok = p_aw && (AWREADY === 1'b1);
			w_ok = p_w && (WREADY === 1'b1);
			b_ok = p_b && (BVALID === 1'b1);
			if (b_ok) begin
				resp = BRESP;
			end
			@(posedge SYS_CLK);
			if (aw_ok) begin
				AWVALID <= 1'b0;
				p_aw = 1'b0;
			end
			if (w_ok) begin
				WVALID <= 1'b0;
				p_w = 1'b0;
			end
			if (b_ok) begin
				BREADY <= 1'b0;
				p_b = 1'b0;
			end
		end
		@(posedge SYS_CLK);
	endtask

	// one bus read; address drops after its taking edge, data kept from the valid cycle
	task automatic rdr(input logic [11:0] a);
		logic p_ar, p_r, ar_ok, r_ok;
		p_ar = 1'b1;
		p_r = 1'b1;
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		while (p_ar || p_r) begin
			@(negedge SYS_CLK);
			ar_ok = p_ar && (ARREADY === 1'b1);
			r_ok = p_r && (RVALID === 1'b1);
			if (r_ok) begin
				rd = RDATA;
				resp = RRESP;
			end
			@(posedge SYS_CLK);
			if (ar_ok) begin
				ARVALID <= 1'b0;
				p_ar = 1'b0;
			end
			if (r_ok) begin
				RREADY <= 1'b0;
				p_r = 1'b0;
			end
		end
		@(posedge SYS_CLK);
	endtask

	// issue one instruction word and expect an okay answer
	task automatic ins(input rsx_pkg::op_t op, input logic [7:0] k, input logic dst,
		input logic [6:0] f);
		wr(12'h000, {13'h0000, op, k, dst, f}, 4'hF);
		chk("instr resp", 32'h0000_0000, {30'h0, resp});
	endtask

	// read a register and compare its value
	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		rdr(a);
		chk(what, exp, rd);
	endtask

	// rotate left into work keeps zero and nibble carry
	task automatic t_rotl();
		wr(12'h214, 32'h0000_0066, 4'hF);
		wr(12'h008, 32'h0000_0007, 4'hF);
		ins(rsx_pkg::OP_ROTL, 8'h00, 1'b0, 7'h05);
		rchk("rotl work", 12'h004, 32'h0000_00CD);
		rchk("rotl status", 12'h008, 32'h0000_001E);
		rchk("rotl file", 12'h214, 32'h0000_0066);
		ins(rsx_pkg::OP_ROTL, 8'h00, 1'b1, 7'h05);
		rchk("rotl to file", 12'h214, 32'h0000_00CC);
	endtask

	// rotate right back into the last file register
	task automatic t_rotr();
		wr(12'h3FC, 32'h0000_0002, 4'hF);
		wr(12'h008, 32'h0000_0001, 4'hF);
		ins(rsx_pkg::OP_ROTR, 8'h00, 1'b1, 7'h7F);
		rchk("rotr file", 12'h3FC, 32'h0000_0081);
		rchk("rotr status", 12'h008, 32'h0000_0018);
		rchk("rotr work", 12'h004, 32'h0000_00CD);
	endtask

	// literal minus work: borrow, zero and top literal
	task automatic t_subl();
		wr(12'h004, 32'h0000_0005, 4'hF);
		ins(rsx_pkg::OP_SUBL, 8'h03, 1'b0, 7'h00);
		rchk("subl work", 12'h004, 32'h0000_00FE);
		rchk("subl flags", 12'h008, 32'h0000_0018);
		wr(12'h004, 32'h0000_0010, 4'hF);
		ins(rsx_pkg::OP_SUBL, 8'h10, 1'b0, 7'h00);
		rchk("subl zero", 12'h004, 32'h0000_0000);
		rchk("subl zflags", 12'h008, 32'h0000_001F);
		ins(rsx_pkg::OP_SUBL, 8'hFF, 1'b0, 7'h00);
		rchk("subl top", 12'h004, 32'h0000_00FF);
		rchk("subl tflags", 12'h008, 32'h0000_001B);
	endtask

	// file minus work to both destinations
	task automatic t_subf();
		wr(12'h200, 32'h0000_002A, 4'hF);
		wr(12'h004, 32'h0000_000F, 4'hF);
		ins(rsx_pkg::OP_SUBF, 8'h00, 1'b1, 7'h00);
		rchk("subf file", 12'h200, 32'h0000_001B);
		rchk("subf work", 12'h004, 32'h0000_000F);
		rchk("subf flags", 12'h008, 32'h0000_0019);
		ins(rsx_pkg::OP_SUBF, 8'h00, 1'b0, 7'h00);
		rchk("subf w dest", 12'h004, 32'h0000_000C);
	endtask

	// power-down, a refused instruction while halted, then wake
	task automatic t_sleep();
		chk("no early clear", 32'h0000_0000, clear_pulses);
		ins(rsx_pkg::OP_SLEEP, 8'h00, 1'b0, 7'h00);
		chk("halted", 32'h0000_0001, {31'h0, OSC_HALT});
		chk("watchdog clears", 32'h0000_0001, clear_pulses);
		rchk("sleep status", 12'h008, 32'h0000_0031);
		ins(rsx_pkg::OP_ROTL, 8'h00, 1'b0, 7'h00);
		rchk("asleep work", 12'h004, 32'h0000_000C);
		WAKE <= 1'b1;
		@(posedge SYS_CLK);
		WAKE <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		chk("woken", 32'h0000_0000, {31'h0, OSC_HALT});
		rchk("wake status", 12'h008, 32'h0000_0011);
		chk("watchdog once", 32'h0000_0001, clear_pulses);
	endtask

	// print counts and verdict, then stop
	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#2000000;
		miscompares++;
		results();
	end

	// main sequence
	initial begin
		SYS_RST = 1'b1;
		AWADDR = 12'h000;
		AWVALID = 1'b0;
		WDATA = 32'h0000_0000;
		WSTRB = 4'h0;
		WVALID = 1'b0;
		BREADY = 1'b0;
		ARADDR = 12'h000;
		ARVALID = 1'b0;
		RREADY = 1'b0;
		WAKE = 1'b0;
		repeat (20) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		@(posedge SYS_CLK);
		rchk("reset status", 12'h008, 32'h0000_0018);
		rchk("reset work", 12'h004, 32'h0000_0000);
		t_rotl();
		t_rotr();
		t_subl();
		t_subf();
		// an unused operation code must leave work and file alone
		ins(rsx_pkg::OP_NONE, 8'hFF, 1'b1, 7'h00);
		rchk("no-op work", 12'h004, 32'h0000_000C);
		rchk("no-op file", 12'h200, 32'h0000_001B);
		wr(12'h00C, 32'h0000_00FF, 4'hF);
		chk("unmapped write", 32'h0000_0002, {30'h0, resp});
		rchk("unmapped data", 12'h00C, 32'h0000_0000);
		chk("unmapped read", 32'h0000_0002, {30'h0, resp});
		t_sleep();
		results();
	end
endmodule
`default_nettype wire
